// ### rtl/drb_buffer.sv
// Notes on behaviour
// R1: capture every input on rising clock edge
// R2: each captured bit drives A and B copies
// R3: even parity over shared bits and parity
// R4: parity arrives one cycle after its data
// R5: error updates at n+2, valid n+3
// R6: error pin pulled low, else released
// R7: single error holds low two cycles
// R8: consecutive errors keep low while lasting
// R9: error before low power holds through it
// R10: rank inputs excluded from parity
// R11: reset clears stages, outputs low
// R12: reset async, beats gating, error high
// R13: inputs ignored while reset low
// R14: system holds reset until clock stable
// R15: controller drives inputs low after reset; code holds only data and parity low, selects high
// R16: low inputs after reset keep outputs low
// R17: gating plus both selects high holds outputs
// R18: otherwise gated outputs update each edge
// R19: both selects high freeze error output
// R20: tie gating low to disable it
// R21: rank outputs never suspended by gating
module drb_buffer #(
  parameter int WIDTH = drb_pkg::SHARED_WIDTH,
  parameter int RANKS = drb_pkg::RANKS
) (
  input wire logic clk_sys,
  drb_link_if.buffer link,
  output logic [WIDTH-1:0] gated_buffered_out_a,
  output logic [WIDTH-1:0] gated_buffered_out_b,
  output logic [RANKS-1:0] rank_select_out_a,
  output logic [RANKS-1:0] rank_select_out_b,
  output logic [RANKS-1:0] rank_clk_en_out_a,
  output logic [RANKS-1:0] rank_clk_en_out_b,
  output logic [RANKS-1:0] rank_term_out_a,
  output logic [RANKS-1:0] rank_term_out_b,
  output logic low_power_period
);
  // ---------------------------------------------------------------
  // reset and receiver enable
  // ---------------------------------------------------------------
  // the link reset reaches every stage asynchronously, so the outputs
  // drop even while the clock is stopped or the inputs float
  wire resetn = link.reg_resetn; // R12 R13

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] word_q;
  logic par_pend;
  logic mism_q;
  logic err_q;
  logic [1:0] hold_count;

  // ---------------------------------------------------------------
  // gating decode
  // ---------------------------------------------------------------
  wire all_deselect = &link.rank_select_n;
  wire gate_hold = link.select_gating_en && all_deselect; // R17 R18
  wire word_load = !gate_hold;
  wire [WIDTH-1:0] next_word = word_load ? link.shared_cmd_addr_in : word_q;

  // ---------------------------------------------------------------
  // parity decode
  // ---------------------------------------------------------------
  // parity over shared bits only; rank lines never enter
  wire word_odd = ^word_q; // R10
  wire mismatch = word_odd ^ link.parity_in; // R3 R4
  // a held word was already checked when it was taken
  wire next_mism = par_pend && mismatch; // R4

  // ---------------------------------------------------------------
  // error decode
  // ---------------------------------------------------------------
  // a fresh error reloads the count, so a burst keeps the pin low
  wire hold_live = hold_count != 2'h0;
  wire [1:0] reload_hold = drb_pkg::ERR_HOLD_INIT - 2'h1;
  wire [1:0] count_down = hold_live ? hold_count - 2'h1 : hold_count;
  wire [1:0] step_hold = mism_q ? reload_hold : count_down; // R7 R8
  wire raw_err = mism_q || (err_q && hold_live); // R7 R8
  // freeze while deselected stretches an error across low power
  wire err_frozen = all_deselect; // R19 R9
  wire next_err = err_frozen ? err_q : raw_err; // R5
  wire [1:0] next_hold = err_frozen ? hold_count : step_hold;

  // ---------------------------------------------------------------
  // shared word register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin // R11 R16
      word_q <= '0;
    end else begin // R1
      word_q <= next_word;
    end
  end

  // copies come from the same register, so A and B can never skew
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_copy
    assign gated_buffered_out_a[i] = word_q[i]; // R2
    assign gated_buffered_out_b[i] = word_q[i];
  end

  // ---------------------------------------------------------------
  // rank side-band registers
  // ---------------------------------------------------------------
  // these bypass the gating decode, so a rank can always be woken
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin // R11
      rank_select_out_a <= '0;
    end else begin // R1
      rank_select_out_a <= link.rank_select_n; // R2 R21
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rank_select_out_b <= '0;
    end else begin
      rank_select_out_b <= link.rank_select_n; // R2 R21
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rank_clk_en_out_a <= '0;
    end else begin
      rank_clk_en_out_a <= link.rank_clk_en_in; // R2 R21
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rank_clk_en_out_b <= '0;
    end else begin
      rank_clk_en_out_b <= link.rank_clk_en_in;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rank_term_out_a <= '0;
    end else begin
      rank_term_out_a <= link.rank_term_in; // R2 R21
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rank_term_out_b <= '0;
    end else begin
      rank_term_out_b <= link.rank_term_in;
    end
  end

  // both ranks deselected at the last edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      low_power_period <= 1'b0;
    end else begin
      low_power_period <= all_deselect;
    end
  end

  // ---------------------------------------------------------------
  // parity check stage
  // ---------------------------------------------------------------
  // word taken at n meets its parity bit at n+1; registering the
  // result here is what puts the pin change on n+2
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      par_pend <= 1'b0;
    end else begin
      par_pend <= word_load;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mism_q <= 1'b0;
    end else begin
      mism_q <= next_mism; // R5
    end
  end

  // ---------------------------------------------------------------
  // error latch
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin // R12
      err_q <= 1'b0;
    end else begin
      err_q <= next_err;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hold_count <= 2'h0;
    end else begin
      hold_count <= next_hold;
    end
  end

  // ---------------------------------------------------------------
  // open-drain pin
  // ---------------------------------------------------------------
  // only ever pulls low; the board pull-up gives the released level
  assign link.parity_error_n_o = 1'b0; // R6
  assign link.parity_error_n_oe_n = !err_q; // R6 R12
endmodule : drb_buffer

// ### rtl/drb_ctrl.sv
module drb_ctrl (
  input wire logic clk_sys,
  input wire logic resetn,
  drb_link_if.ctrl link,
  input wire logic cmd_valid,
  input wire logic [drb_pkg::SHARED_WIDTH-1:0] cmd_data,
  input wire logic [drb_pkg::RANKS-1:0] cmd_select_n,
  input wire logic [drb_pkg::RANKS-1:0] cmd_clk_en,
  input wire logic [drb_pkg::RANKS-1:0] cmd_term,
  input wire logic gating_en,
  input wire logic buffer_resetn,
  output logic cmd_ready,
  output logic error_seen
);
  // ---------------------------------------------------------------
  // state and registers
  // ---------------------------------------------------------------
  drb_pkg::drb_ctl_type state;
  drb_pkg::drb_ctl_type next_state;
  logic [7:0] quiet_count;
  logic [drb_pkg::SHARED_WIDTH-1:0] data_q;
  logic parity_q;
  logic [drb_pkg::RANKS-1:0] sel_q;
  logic [drb_pkg::RANKS-1:0] cke_q;
  logic [drb_pkg::RANKS-1:0] odt_q;
  logic gate_q;
  logic rst_q;
  wire quiet_done = quiet_count == 8'(drb_pkg::ACT_CYCLES - 1);
  wire issue = state == drb_pkg::DRB_RUN && cmd_valid;
  // parity trails data by one cycle, so it covers the word driven the cycle before
  wire next_parity = ^data_q;
  wire err_low = !link.parity_error_n_oe_n && !link.parity_error_n_o;

  always_comb begin
    next_state = state;
    unique case (state)
      drb_pkg::DRB_RESET: next_state = drb_pkg::DRB_QUIET;
      drb_pkg::DRB_QUIET: if (quiet_done) next_state = drb_pkg::DRB_RUN;
      drb_pkg::DRB_RUN: next_state = drb_pkg::DRB_RUN;
      default: next_state = drb_pkg::DRB_RESET;
    endcase
    if (!buffer_resetn) next_state = drb_pkg::DRB_RESET; // R14
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= drb_pkg::DRB_RESET;
      quiet_count <= 8'h00;
      data_q <= '0;
      parity_q <= 1'b0;
      sel_q <= '1;
      cke_q <= '0;
      odt_q <= '0;
      gate_q <= 1'b0;
      rst_q <= 1'b0;
      cmd_ready <= 1'b0;
      error_seen <= 1'b0;
    end else begin
      state <= next_state;
      quiet_count <= state == drb_pkg::DRB_QUIET ? quiet_count + 8'h01
                                                 : 8'h00;
      rst_q <= buffer_resetn; // R14
      gate_q <= gating_en; // R20
      // data and parity held low while receivers wake up
      data_q <= issue ? cmd_data : '0; // R15
      sel_q <= issue ? cmd_select_n : '1;
      cke_q <= cmd_clk_en;
      odt_q <= cmd_term;
      parity_q <= state == drb_pkg::DRB_RUN ? next_parity : 1'b0; // R3 R4
      cmd_ready <= next_state == drb_pkg::DRB_RUN;
      error_seen <= err_low;
    end
  end

  assign link.shared_cmd_addr_in = data_q;
  assign link.parity_in = parity_q;
  assign link.rank_select_n = sel_q;
  assign link.rank_clk_en_in = cke_q;
  assign link.rank_term_in = odt_q;
  assign link.select_gating_en = gate_q;
  assign link.reg_resetn = rst_q;
endmodule : drb_ctrl

// ### rtl/drb_link_if.sv
interface drb_link_if;
  logic [drb_pkg::SHARED_WIDTH-1:0] shared_cmd_addr_in;
  logic parity_in;
  logic [drb_pkg::RANKS-1:0] rank_select_n;
  logic [drb_pkg::RANKS-1:0] rank_clk_en_in;
  logic [drb_pkg::RANKS-1:0] rank_term_in;
  logic select_gating_en;
  logic reg_resetn;
  logic parity_error_n_o;
  logic parity_error_n_oe_n;
  modport ctrl (
    output shared_cmd_addr_in,
    output parity_in,
    output rank_select_n,
    output rank_clk_en_in,
    output rank_term_in,
    output select_gating_en,
    output reg_resetn,
    input parity_error_n_o,
    input parity_error_n_oe_n
  );
  modport buffer (
    input shared_cmd_addr_in,
    input parity_in,
    input rank_select_n,
    input rank_clk_en_in,
    input rank_term_in,
    input select_gating_en,
    input reg_resetn,
    output parity_error_n_o,
    output parity_error_n_oe_n
  );
endinterface : drb_link_if

// ### rtl/drb_pkg.sv
package drb_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int SHARED_WIDTH = 22;
  localparam int RANKS = 2;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int ERR_HOLD_CYCLES = 2;
  localparam int ACT_TIME_NS = 50;
  localparam int CLK_PERIOD_NS = 5;
  localparam int ACT_CYCLES = (ACT_TIME_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam logic [1:0] ERR_HOLD_INIT = 2'(ERR_HOLD_CYCLES);
  // ---------------------------------------------------------------
  // controller states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DRB_RESET = 3'h1,
    DRB_QUIET = 3'h2,
    DRB_RUN = 3'h4
  } drb_ctl_type;
endpackage : drb_pkg

// ### testbench/ddr2_registered_buffer_parity_tb.sv
module ddr2_registered_buffer_parity_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin \
    fail_count++; $display("MISMATCH %0t %s", $time, m); end end
  int fail_count = 0;
  int samples_checked = 0;
  logic clk_sys = 0, resetn = 0, cmd_valid = 0, gating_en = 0;
  logic buffer_resetn = 1, cmd_ready, error_seen;
  logic [21:0] cmd_data = '0;
  logic [1:0] cmd_select_n = 2'h2, cmd_clk_en = 2'h1, cmd_term = 2'h2;
  logic [21:0] qa [2], qb [2];
  logic [1:0] sa [2], sb [2], ca [2], cb [2], ta [2], tb [2];
  logic lp [2];
  drb_link_if lk [2] ();
  wire e2 = lk[1].parity_error_n_oe_n;
  drb_ctrl drb_ctrl_i (.clk_sys, .resetn, .link(lk[0]), .cmd_valid,
    .cmd_data, .cmd_select_n, .cmd_clk_en, .cmd_term, .gating_en,
    .buffer_resetn, .cmd_ready, .error_seen);
  for (genvar g = 0; g < 2; g++) begin : bufs
    drb_buffer drb_buffer_i (.clk_sys, .link(lk[g]),
      .gated_buffered_out_a(qa[g]), .gated_buffered_out_b(qb[g]),
      .rank_select_out_a(sa[g]), .rank_select_out_b(sb[g]),
      .rank_clk_en_out_a(ca[g]), .rank_clk_en_out_b(cb[g]),
      .rank_term_out_a(ta[g]), .rank_term_out_b(tb[g]),
      .low_power_period(lp[g]));
  end
  drb_buffer_asserts drb_buffer_asserts_i (.clk_sys,
    .reg_resetn(lk[0].reg_resetn),
    .shared_cmd_addr_in(lk[0].shared_cmd_addr_in),
    .parity_in(lk[0].parity_in), .rank_select_n(lk[0].rank_select_n),
    .parity_error_n_o(lk[0].parity_error_n_o),
    .parity_error_n_oe_n(lk[0].parity_error_n_oe_n));
  initial forever #2.5 clk_sys = ~clk_sys;
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  // second link: the bench plays a controller that may break parity
  task automatic drv(logic [21:0] d, logic p, logic [1:0] s);
    @(posedge clk_sys);
    lk[1].shared_cmd_addr_in <= d;
    lk[1].parity_in <= p;
    lk[1].rank_select_n <= s;
    lk[1].rank_clk_en_in <= ~d[1:0];
    lk[1].rank_term_in <= d[1:0];
  endtask : drv
  task automatic t_reset();
    repeat (10) @(posedge clk_sys);
    #1 `CK(qa[1], 22'h0, "reset q")
    `CK(e2, 1'b1, "reset err")
    drv(22'h0, 1'b0, 2'h2);
    resetn <= 1;
    lk[1].reg_resetn <= 1;
    repeat (12) drv(22'h0, 1'b0, 2'h2);
    #1 `CK({qa[1], e2}, 23'h1, "quiet")
  endtask : t_reset
  task automatic t_fanout();
    for (int i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge clk_sys);
    `CK(cmd_ready, 1'b1, "not ready")
    @(posedge clk_sys);
    cmd_data <= 22'h2A5C3F;
    cmd_valid <= 1;
    repeat (5) @(posedge clk_sys);
    #1 `CK({qa[0], qb[0]}, {2{22'h2A5C3F}}, "fanout")
    `CK({sa[0], sb[0], ca[0], cb[0], ta[0], tb[0]}, 12'hA5A, "rank")
    `CK(error_seen, 1'b0, "false error")
    @(posedge clk_sys);
    buffer_resetn <= 0;
    @(posedge clk_sys);
    #1 `CK(qa[0], 22'h0, "mid reset")
    `CK(cmd_ready, 1'b0, "ready in reset")
    @(posedge clk_sys);
    buffer_resetn <= 1;
  endtask : t_fanout
  task automatic t_parity();
    drv(22'h1, 1'b0, 2'h2);
    repeat (2) drv(22'h0, 1'b0, 2'h2);
    #1 `CK(e2, 1'b1, "early")
    drv(22'h0, 1'b0, 2'h2);
    #1 `CK(e2, 1'b0, "late")
    drv(22'h0, 1'b0, 2'h2);
    #1 `CK(e2, 1'b0, "hold")
    repeat (4) drv(22'h0, 1'b0, 2'h2);
    #1 `CK(e2, 1'b1, "release")
    for (int i = 0; i < 6; i++) begin
      drv(22'h1, 1'b0, 2'h1);
      if (i > 2) #1 `CK(e2, 1'b0, "burst")
    end
    drv(22'h0, 1'b1, 2'h3);
    repeat (3) drv(22'h0, 1'b0, 2'h3);
    #1 `CK(e2, 1'b0, "frozen")
    repeat (6) drv(22'h0, 1'b0, 2'h2);
    #1 `CK(e2, 1'b1, "clear")
  endtask : t_parity
  task automatic t_gate();
    drv(22'h3, 1'b0, 2'h1);
    lk[1].select_gating_en <= 1;
    repeat (2) drv(22'h5, 1'b0, 2'h3);
    #1 `CK(qa[1], 22'h3, "held")
    `CK({sa[1], ta[1], lp[1]}, 5'h1B, "rank live")
    repeat (2) drv(22'h5, 1'b0, 2'h2);
    #1 `CK(qb[1], 22'h5, "open")
  endtask : t_gate
  initial begin
    #20us;
    fail_count++;
    final_report();
  end
  initial begin
    lk[1].reg_resetn = 0;
    lk[1].shared_cmd_addr_in = '1;
    lk[1].parity_in = 1;
    lk[1].rank_select_n = 2'h3;
    lk[1].rank_clk_en_in = 2'h3;
    lk[1].rank_term_in = 2'h3;
    lk[1].select_gating_en = 0;
    t_reset();
    t_fanout();
    t_parity();
    t_gate();
    final_report();
  end
endmodule : ddr2_registered_buffer_parity_tb

// ### testbench/drb_buffer_asserts.sv
module drb_buffer_asserts (
  input wire logic clk_sys,
  input wire logic reg_resetn,
  input wire logic [drb_pkg::SHARED_WIDTH-1:0] shared_cmd_addr_in,
  input wire logic parity_in,
  input wire logic [drb_pkg::RANKS-1:0] rank_select_n,
  input wire logic parity_error_n_o,
  input wire logic parity_error_n_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // word of the edge before, paired with this edge's parity bit
  // ---------------------------------------------------------------
  logic [drb_pkg::SHARED_WIDTH-1:0] prev;
  logic prev_idle;
  wire idle = &rank_select_n;
  wire err = !parity_error_n_oe_n;
  always_ff @(posedge clk_sys or negedge reg_resetn) begin
    if (!reg_resetn) begin
      prev <= '0;
      prev_idle <= 1'b1;
    end else begin
      prev <= shared_cmd_addr_in;
      prev_idle <= idle;
    end
  end
  // idle edges on either side are skipped: freeze makes them ambiguous
  wire live = !idle && !prev_idle;
  wire odd = ^{prev, parity_in};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reg_resetn);
  chk_odd_pulls_low: assert property (
    live && odd ##1 !idle |=> err) else $error("parity error missed");
  chk_even_stays_high: assert property (
    live && !odd ##1 (!idle && !err) |=> !err) else $error("false error");
  chk_pin_drives_low: assert property (
    parity_error_n_o == 1'b0) else $error("error pin not low");
  chk_error_min_hold: assert property (
    $fell(parity_error_n_oe_n) |=> err) else $error("error too short");
  chk_error_rise_late: assert property (
    $rose(parity_error_n_oe_n) |-> $past(err, 2)) else $error("short low");
  chk_idle_freezes: assert property (
    idle [*3] |-> $stable(err)) else $error("error moved while idle");
  chk_reset_release: assert property (
    $rose(reg_resetn) |-> !err) else $error("error after reset");
  chk_quiet_start: assert property (
    $rose(reg_resetn) |-> (shared_cmd_addr_in == '0 && !parity_in) [*8])
    else $error("inputs not quiet");
  cover property ($fell(parity_error_n_oe_n));
  cover property (idle [*3]);
  cover property ($rose(reg_resetn));
endmodule : drb_buffer_asserts
